// [sqtl_host.sv]
`timescale 1ns/1ps
module sqtl_host (
    input wire logic pclk,
    output logic alarm_reset_input,
    output logic counter_clear_input,
    output logic pulse_inhibit_input,
    output logic torque_limit_switch_input,
    output logic [8:0] forward_analog_torque_limit,
    output logic [8:0] reverse_analog_torque_limit,
    output logic command_pulse_strobe
);
    initial begin
        alarm_reset_input = 1'b0;
        counter_clear_input = 1'b0;
        pulse_inhibit_input = 1'b0;
        torque_limit_switch_input = 1'b0;
        forward_analog_torque_limit = 9'h032;
        reverse_analog_torque_limit = 9'h03C;
        command_pulse_strobe = 1'b0;
    end
    // levels move only at an edge and stand until the next call
    task automatic drive(input int which, input logic val);
        @(posedge pclk);
        case (which)
            0: alarm_reset_input <= val;
            1: counter_clear_input <= val;
            2: pulse_inhibit_input <= val;
            default: torque_limit_switch_input <= val;
        endcase
    endtask
    task automatic set_lim(input logic [8:0] f, input logic [8:0] r);
        @(posedge pclk);
        forward_analog_torque_limit <= f;
        reverse_analog_torque_limit <= r;
    endtask
    task automatic strobes(input int n);
        repeat (n) begin
            @(posedge pclk);
            command_pulse_strobe <= 1'b1;
            @(posedge pclk);
            command_pulse_strobe <= 1'b0;
        end
    endtask
endmodule

// [sqtl_pkg.sv]
package sqtl_pkg;
    localparam int CLK_NS = 20;
    // sample periods and minimum widths, in ns
    localparam int T_SMP0_NS = 166000;
    localparam int T_SMP1_NS = 333000;
    localparam int T_SMP2_NS = 1000000;
    localparam int T_SMP3_NS = 1666000;
    localparam int T_AR_NS = 120000000;
    localparam int T_CLR500_NS = 500000;
    localparam int T_CLR1MS_NS = 1000000;
    localparam int T_CLR100_NS = 100000;
    // consecutive agreeing samples before a qualified input moves
    localparam int MATCH_N = 3;
    // register byte addresses
    localparam logic [7:0] A_CFG = 8'h00;
    localparam logic [7:0] A_TLIM12 = 8'h04;
    localparam logic [7:0] A_TLIMX = 8'h08;
    localparam logic [7:0] A_STAT = 8'h0C;
    localparam logic [7:0] A_PCNT = 8'h10;
    // cfg field positions, and the high-half position in the limit registers
    localparam int F_CISP = 0;
    localparam int F_ARCS = 2;
    localparam int F_CCC = 4;
    localparam int F_PIE = 8;
    localparam int F_PISP = 12;
    localparam int F_PUS = 16;
    localparam int F_TLM = 20;
    localparam int F_TQM = 24;
    localparam int F_HI = 16;
    // reset values
    localparam logic [1:0] R_CISP = 2'h0;
    localparam logic R_ARCS = 1'h0;
    localparam logic [2:0] R_CCC = 3'h3;
    localparam logic R_PIE = 1'h1;
    localparam logic [2:0] R_PISP = 3'h0;
    localparam logic R_PUS = 1'h0;
    localparam logic [2:0] R_TLM = 3'h1;
    localparam logic [8:0] R_TLIM = 9'h1F4;
    // error-counter clear modes, the raw inhibit sampling code and the clear states
    localparam logic [2:0] CLR_OFF = 3'h0;
    localparam logic [2:0] CLR_LVL500 = 3'h1;
    localparam logic [2:0] CLR_LVL1MS = 3'h2;
    localparam logic [2:0] CLR_EDG100 = 3'h3;
    localparam logic [2:0] CLR_EDG1MS = 3'h4;
    localparam logic [2:0] PISP_RAW = 3'h4;
    typedef enum logic [2:0] {
        CS_IDLE = 3'b001,
        CS_TIME = 3'b010,
        CS_DONE = 3'b100
    } sqtl_clr_t;
endpackage

// [sqtl_tb.sv]
`timescale 1ns/1ps
module tb;
    typedef struct packed {logic [2:0] m; logic sw; logic tq; logic [8:0] f; logic [8:0] r;} sqtl_row_t;
    localparam sqtl_row_t ROWS [10] = '{
        '{3'h0, 1'b0, 1'b0, 9'h032, 9'h03C}, '{3'h4, 1'b0, 1'b0, 9'h032, 9'h03C},
        '{3'h5, 1'b0, 1'b0, 9'h032, 9'h03C}, '{3'h1, 1'b0, 1'b0, 9'h064, 9'h064},
        '{3'h2, 1'b0, 1'b0, 9'h064, 9'h0C8}, '{3'h3, 1'b0, 1'b0, 9'h064, 9'h064},
        '{3'h3, 1'b1, 1'b0, 9'h0C8, 9'h0C8}, '{3'h6, 1'b0, 1'b0, 9'h064, 9'h0C8},
        '{3'h6, 1'b1, 1'b0, 9'h12C, 9'h190}, '{3'h2, 1'b0, 1'b1, 9'h064, 9'h064}};
    localparam int PER [5] = '{20, 40, 120, 200, 20};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r, c0;
    logic e, ari, cci, pii, tsi, cps, arc, ecc, pce, pue, ecc_q;
    logic [8:0] fal, ral, ftl, rtl;
    int err_count, comparisons, rc, r0;
    sqtl_host u_host (.pclk(pclk), .alarm_reset_input(ari), .counter_clear_input(cci),
        .pulse_inhibit_input(pii), .torque_limit_switch_input(tsi), .forward_analog_torque_limit(fal),
        .reverse_analog_torque_limit(ral), .command_pulse_strobe(cps));
    sqtl_top #(.P_SMP0(20), .P_AR(200), .P_CLR500(30),
        .P_CLR1MS(50), .P_CLR100(10)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .alarm_reset_input(ari), .counter_clear_input(cci),
        .pulse_inhibit_input(pii), .torque_limit_switch_input(tsi), .forward_analog_torque_limit(fal),
        .reverse_analog_torque_limit(ral), .command_pulse_strobe(cps), .alarm_reset_confirmed(arc),
        .error_counter_clear(ecc), .pulse_count_enable(pce), .position_unit_encoder(pue),
        .forward_torque_limit(ftl), .reverse_torque_limit(rtl));
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        ecc_q <= ecc;
        if (ecc === 1'b1 && ecc_q !== 1'b1) rc <= rc + 1;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        comparisons++;
        if (s !== x) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, s, x);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic clr(input logic [2:0] mode, input int thr, input logic ef, input int er);
        apb(1'b1, sqtl_pkg::A_CFG, {25'h0, mode, 4'h0} | 32'h00000100);
        r0 = rc;
        u_host.drive(1, 1'b1);
        cyc(thr - 2);
        chk(ecc, 1'b0);
        cyc(10);
        chk(ecc, ef);
        chk(rc - r0, er);
        u_host.drive(1, 1'b0);
        cyc(4);
        chk(ecc, 1'b0);
        u_host.drive(1, 1'b1);
        cyc(thr / 2);
        u_host.drive(1, 1'b0);
        cyc(thr);
        chk(rc - r0, er);
        $display("clear mode %0d done", mode);
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        test_done;
    end
    initial begin
        err_count = 0;
        comparisons = 0;
        rc = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        cyc(1);
        chk(ftl, 9'h1F4);
        chk(rtl, 9'h1F4);
        chk({pce, pue, arc, ecc}, 4'h8);
        apb(1'b0, sqtl_pkg::A_CFG, 32'h0);
        chk(r, 32'h00100130);
        apb(1'b0, sqtl_pkg::A_TLIM12, 32'h0);
        chk(r, 32'h01F401F4);
        apb(1'b0, sqtl_pkg::A_TLIMX, 32'h0);
        chk(r, 32'h01F401F4);
        apb(1'b0, 8'h20, 32'h0);
        chk({e, r}, 33'h100000000);
        $display("reset test done");
        apb(1'b1, sqtl_pkg::A_TLIM12, 32'h00C80064);
        apb(1'b1, sqtl_pkg::A_TLIMX, 32'h0190012C);
        for (int i = 0; i < 10; i++) begin
            u_host.drive(3, ROWS[i].sw);
            apb(1'b1, sqtl_pkg::A_CFG, {7'h0, ROWS[i].tq, 1'b0, ROWS[i].m, 20'h00100});
            cyc(3);
            chk({ftl, rtl}, {ROWS[i].f, ROWS[i].r});
        end
        u_host.set_lim(9'h0AA, 9'h155);
        apb(1'b1, sqtl_pkg::A_CFG, 32'h00400100);
        cyc(3);
        chk({ftl, rtl}, {9'h0AA, 9'h155});
        $display("torque table done");
        clr(sqtl_pkg::CLR_OFF, 30, 1'b0, 0);
        clr(sqtl_pkg::CLR_LVL500, 30, 1'b1, 1);
        clr(sqtl_pkg::CLR_LVL1MS, 50, 1'b1, 1);
        clr(sqtl_pkg::CLR_EDG100, 10, 1'b0, 1);
        clr(sqtl_pkg::CLR_EDG1MS, 50, 1'b0, 1);
        for (int c = 0; c < 5; c++) begin
            apb(1'b1, sqtl_pkg::A_CFG, {17'h0, c[2:0], 12'h000});
            u_host.drive(2, 1'b1);
            cyc(PER[c]);
            if (c < 4) chk(pce, 1'b1);
            cyc((c < 4) ? 2 * PER[c] + 4 : 3);
            chk(pce, 1'b0);
            apb(1'b0, sqtl_pkg::A_PCNT, 32'h0);
            c0 = r;
            u_host.strobes(4);
            apb(1'b0, sqtl_pkg::A_PCNT, 32'h0);
            chk(r, c0);
            u_host.drive(2, 1'b0);
            cyc(3 * PER[c] + 4);
            chk(pce, 1'b1);
        end
        u_host.strobes(4);
        apb(1'b0, sqtl_pkg::A_PCNT, 32'h0);
        chk(r, c0 + 32'h4);
        apb(1'b1, sqtl_pkg::A_CFG, 32'h00004100);
        u_host.drive(2, 1'b1);
        cyc(30);
        chk(pce, 1'b1);
        u_host.drive(2, 1'b0);
        $display("inhibit tests done");
        apb(1'b1, sqtl_pkg::A_CFG, 32'h00000100);
        u_host.drive(0, 1'b1);
        cyc(190);
        chk(arc, 1'b0);
        cyc(20);
        chk(arc, 1'b1);
        u_host.drive(0, 1'b0);
        cyc(3);
        chk(arc, 1'b0);
        apb(1'b1, sqtl_pkg::A_CFG, 32'h00000104);
        u_host.drive(0, 1'b1);
        cyc(10);
        chk(arc, 1'b0);
        cyc(60);
        chk(arc, 1'b1);
        u_host.drive(0, 1'b0);
        $display("alarm tests done");
        apb(1'b1, sqtl_pkg::A_CFG, 32'h00010100);
        apb(1'b0, sqtl_pkg::A_CFG, 32'h0);
        chk(r, 32'h00010100);
        chk(pue, 1'b1);
        $display("unit test done");
        test_done;
    end
endmodule

// [sqtl_top.sv]
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ps
module sqtl_tick (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [31:0] period,
    output logic tick
);
    logic [31:0] cnt_r, cnt_nxt, per_r;
    always_comb begin
        tick = 1'b0;
        cnt_nxt = cnt_r + 32'h1;
        if (period != per_r) begin
            cnt_nxt = 32'h0;
        end else if (cnt_r >= period - 32'h1) begin
            cnt_nxt = 32'h0;
            tick = 1'b1;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 32'h0;
            per_r <= 32'h0;
        end else begin
            cnt_r <= cnt_nxt;
            per_r <= period;
        end
    end
endmodule

module sqtl_top #(
    parameter int P_SMP0 = sqtl_pkg::T_SMP0_NS / sqtl_pkg::CLK_NS,
    // longer periods scale from the shortest, in whole microseconds
    parameter int P_SMP1 = P_SMP0 * (sqtl_pkg::T_SMP1_NS / 1000) / (sqtl_pkg::T_SMP0_NS / 1000),
    parameter int P_SMP2 = P_SMP0 * (sqtl_pkg::T_SMP2_NS / 1000) / (sqtl_pkg::T_SMP0_NS / 1000),
    parameter int P_SMP3 = P_SMP0 * (sqtl_pkg::T_SMP3_NS / 1000) / (sqtl_pkg::T_SMP0_NS / 1000),
    parameter int P_AR = (sqtl_pkg::T_AR_NS + sqtl_pkg::CLK_NS - 1) / sqtl_pkg::CLK_NS,
    parameter int P_CLR500 = (sqtl_pkg::T_CLR500_NS + sqtl_pkg::CLK_NS - 1) / sqtl_pkg::CLK_NS,
    parameter int P_CLR1MS = (sqtl_pkg::T_CLR1MS_NS + sqtl_pkg::CLK_NS - 1) / sqtl_pkg::CLK_NS,
    parameter int P_CLR100 = (sqtl_pkg::T_CLR100_NS + sqtl_pkg::CLK_NS - 1) / sqtl_pkg::CLK_NS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic alarm_reset_input,
    input wire logic counter_clear_input,
    input wire logic pulse_inhibit_input,
    input wire logic torque_limit_switch_input,
    input wire logic [8:0] forward_analog_torque_limit,
    input wire logic [8:0] reverse_analog_torque_limit,
    input wire logic command_pulse_strobe,
    output logic alarm_reset_confirmed,
    output logic error_counter_clear,
    output logic pulse_count_enable,
    output logic position_unit_encoder,
    output logic [8:0] forward_torque_limit,
    output logic [8:0] reverse_torque_limit
);
    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [1:0] cisp_r, cisp_nxt;
    logic arcs_r, arcs_nxt;
    logic [2:0] ccc_r, ccc_nxt;
    logic pie_r, pie_nxt;
    logic [2:0] pisp_r, pisp_nxt;
    logic pus_r, pus_nxt;
    logic [2:0] tlm_r, tlm_nxt;
    logic tqm_r, tqm_nxt;
    logic [8:0] tl1_r, tl1_nxt, tl2_r, tl2_nxt;
    logic [8:0] tlf_r, tlf_nxt, tlr_r, tlr_nxt;
    logic [15:0] pcnt_r, pcnt_nxt;
    logic inh_q_r, ar_q_r;
    logic wr;
    assign wr = psel && penable && pwrite;
    assign pready = 1'b1;
    always_comb begin
        cisp_nxt = cisp_r;
        arcs_nxt = arcs_r;
        ccc_nxt = ccc_r;
        pie_nxt = pie_r;
        pisp_nxt = pisp_r;
        pus_nxt = pus_r;
        tlm_nxt = tlm_r;
        tqm_nxt = tqm_r;
        tl1_nxt = tl1_r;
        tl2_nxt = tl2_r;
        tlf_nxt = tlf_r;
        tlr_nxt = tlr_r;
        if (wr && paddr == sqtl_pkg::A_CFG) begin
            cisp_nxt = pwdata[sqtl_pkg::F_CISP +: 2];
            arcs_nxt = pwdata[sqtl_pkg::F_ARCS];
            ccc_nxt = pwdata[sqtl_pkg::F_CCC +: 3];
            pie_nxt = pwdata[sqtl_pkg::F_PIE];
            pisp_nxt = pwdata[sqtl_pkg::F_PISP +: 3];
            pus_nxt = pwdata[sqtl_pkg::F_PUS];
            tlm_nxt = pwdata[sqtl_pkg::F_TLM +: 3];
            tqm_nxt = pwdata[sqtl_pkg::F_TQM];
        end else if (wr && paddr == sqtl_pkg::A_TLIM12) begin
            tl1_nxt = pwdata[8:0];
            tl2_nxt = pwdata[sqtl_pkg::F_HI +: 9];
        end else if (wr && paddr == sqtl_pkg::A_TLIMX) begin
            tlf_nxt = pwdata[8:0];
            tlr_nxt = pwdata[sqtl_pkg::F_HI +: 9];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cisp_r <= sqtl_pkg::R_CISP;
            arcs_r <= sqtl_pkg::R_ARCS;
            ccc_r <= sqtl_pkg::R_CCC;
            pie_r <= sqtl_pkg::R_PIE;
            pisp_r <= sqtl_pkg::R_PISP;
            pus_r <= sqtl_pkg::R_PUS;
            tlm_r <= sqtl_pkg::R_TLM;
            tqm_r <= 1'b0;
            tl1_r <= sqtl_pkg::R_TLIM;
            tl2_r <= sqtl_pkg::R_TLIM;
            tlf_r <= sqtl_pkg::R_TLIM;
            tlr_r <= sqtl_pkg::R_TLIM;
        end else begin
            cisp_r <= cisp_nxt;
            arcs_r <= arcs_nxt;
            ccc_r <= ccc_nxt;
            pie_r <= pie_nxt;
            pisp_r <= pisp_nxt;
            pus_r <= pus_nxt;
            tlm_r <= tlm_nxt;
            tqm_r <= tqm_nxt;
            tl1_r <= tl1_nxt;
            tl2_r <= tl2_nxt;
            tlf_r <= tlf_nxt;
            tlr_r <= tlr_nxt;
        end
    end
    always_comb begin
        prdata = 32'h0;
        pslverr = 1'b0;
        if (paddr == sqtl_pkg::A_CFG) begin
            prdata[sqtl_pkg::F_CISP +: 2] = cisp_r;
            prdata[sqtl_pkg::F_ARCS] = arcs_r;
            prdata[sqtl_pkg::F_CCC +: 3] = ccc_r;
            prdata[sqtl_pkg::F_PIE] = pie_r;
            prdata[sqtl_pkg::F_PISP +: 3] = pisp_r;
            prdata[sqtl_pkg::F_PUS] = pus_r;
            prdata[sqtl_pkg::F_TLM +: 3] = tlm_r;
            prdata[sqtl_pkg::F_TQM] = tqm_r;
        end else if (paddr == sqtl_pkg::A_TLIM12) begin
            prdata = {7'h0, tl2_r, 7'h0, tl1_r};
        end else if (paddr == sqtl_pkg::A_TLIMX) begin
            prdata = {7'h0, tlr_r, 7'h0, tlf_r};
        end else if (paddr == sqtl_pkg::A_STAT) begin
            prdata = {4'h0, error_counter_clear, inh_q_r, ar_q_r, reverse_torque_limit,
                      7'h0, forward_torque_limit};
        end else if (paddr == sqtl_pkg::A_PCNT) begin
            prdata = {16'h0, pcnt_r};
        end else begin
            pslverr = psel && penable;
        end
    end
    assign position_unit_encoder = pus_r;

    ////////////////////////////////////////////////////////////////////////
    // sampling ticks
    function automatic logic [31:0] per_of(input logic [2:0] code);
        logic [31:0] p;
        p = 32'(P_SMP0);
        case (code)
            3'h1: p = 32'(P_SMP1);
            3'h2: p = 32'(P_SMP2);
            3'h3: p = 32'(P_SMP3);
            default: p = 32'(P_SMP0);
        endcase
        return p;
    endfunction
    logic gen_tick, inh_tick;
    sqtl_tick u_gen_tick (
        .pclk(pclk),
        .presetn(presetn),
        .period(per_of({1'b0, cisp_r})),
        .tick(gen_tick)
    );
    sqtl_tick u_inh_tick (
        .pclk(pclk),
        .presetn(presetn),
        .period(per_of(pisp_r)),
        .tick(inh_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // inhibit qualification and pulse counter
    logic [2:0] inh_h_r, inh_h_nxt;
    logic inh_q_nxt;
    always_comb begin
        inh_h_nxt = inh_h_r;
        inh_q_nxt = inh_q_r;
        if (inh_tick) begin
            inh_h_nxt = {inh_h_r[1:0], pulse_inhibit_input};
            if (pisp_r == sqtl_pkg::PISP_RAW) begin
                inh_q_nxt = pulse_inhibit_input;
            end else if (inh_h_nxt == {sqtl_pkg::MATCH_N{inh_h_nxt[0]}}) begin
                inh_q_nxt = inh_h_nxt[0];
            end
        end
    end
    assign pulse_count_enable = !(!pie_r && inh_q_r);
    always_comb begin
        pcnt_nxt = pcnt_r;
        if (command_pulse_strobe && pulse_count_enable) begin
            pcnt_nxt = pcnt_r + 16'h1;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inh_h_r <= 3'h0;
            inh_q_r <= 1'b0;
            pcnt_r <= 16'h0;
        end else begin
            inh_h_r <= inh_h_nxt;
            inh_q_r <= inh_q_nxt;
            pcnt_r <= pcnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // alarm reset confirmation
    logic [31:0] ar_cnt_r, ar_cnt_nxt;
    logic [2:0] ar_h_r, ar_h_nxt;
    logic ar_q_nxt;
    always_comb begin
        ar_cnt_nxt = 32'h0;
        ar_h_nxt = ar_h_r;
        ar_q_nxt = ar_q_r;
        if (!arcs_r) begin
            if (alarm_reset_input) begin
                ar_cnt_nxt = (ar_cnt_r < 32'(P_AR)) ? ar_cnt_r + 32'h1 : ar_cnt_r;
            end
            ar_q_nxt = alarm_reset_input && ar_cnt_nxt >= 32'(P_AR);
        end else if (gen_tick) begin
            ar_h_nxt = {ar_h_r[1:0], alarm_reset_input};
            if (ar_h_nxt == {sqtl_pkg::MATCH_N{ar_h_nxt[0]}}) begin
                ar_q_nxt = ar_h_nxt[0];
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ar_cnt_r <= 32'h0;
            ar_h_r <= 3'h0;
            ar_q_r <= 1'b0;
        end else begin
            ar_cnt_r <= ar_cnt_nxt;
            ar_h_r <= ar_h_nxt;
            ar_q_r <= ar_q_nxt;
        end
    end
    assign alarm_reset_confirmed = ar_q_r;

    ////////////////////////////////////////////////////////////////////////
    // error counter clear
    sqtl_pkg::sqtl_clr_t cs_r, cs_nxt;
    logic [31:0] cc_r, cc_nxt, thr;
    logic arm_r, arm_nxt, clr_r, clr_nxt, edge_m;
    logic [2:0] ccm_r;
    always_comb begin
        case (ccc_r)
            sqtl_pkg::CLR_LVL500: thr = 32'(P_CLR500);
            sqtl_pkg::CLR_EDG100: thr = 32'(P_CLR100);
            default: thr = 32'(P_CLR1MS);
        endcase
    end
    assign edge_m = ccc_r == sqtl_pkg::CLR_EDG100 || ccc_r == sqtl_pkg::CLR_EDG1MS;
    always_comb begin
        cs_nxt = cs_r;
        cc_nxt = cc_r;
        clr_nxt = 1'b0;
        arm_nxt = arm_r || !counter_clear_input;
        case (cs_r)
            sqtl_pkg::CS_IDLE: begin
                cc_nxt = 32'h0;
                if (counter_clear_input && ccc_r != sqtl_pkg::CLR_OFF && (arm_r || !edge_m)) begin
                    cs_nxt = sqtl_pkg::CS_TIME;
                end
            end
            sqtl_pkg::CS_TIME: begin
                cc_nxt = cc_r + 32'h1;
                if (!counter_clear_input) begin
                    cs_nxt = sqtl_pkg::CS_IDLE;
                end else if (cc_r >= thr - 32'h1) begin
                    cs_nxt = sqtl_pkg::CS_DONE;
                    clr_nxt = 1'b1;
                    arm_nxt = 1'b0;
                end
            end
            sqtl_pkg::CS_DONE: begin
                clr_nxt = counter_clear_input && !edge_m;
                if (!counter_clear_input) begin
                    cs_nxt = sqtl_pkg::CS_IDLE;
                end
            end
            default: cs_nxt = sqtl_pkg::CS_IDLE;
        endcase
        if (ccc_r != ccm_r || ccc_r == sqtl_pkg::CLR_OFF) begin
            cs_nxt = sqtl_pkg::CS_IDLE;
            clr_nxt = 1'b0;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs_r <= sqtl_pkg::CS_IDLE;
            cc_r <= 32'h0;
            arm_r <= 1'b0;
            clr_r <= 1'b0;
            ccm_r <= sqtl_pkg::R_CCC;
        end else begin
            cs_r <= cs_nxt;
            cc_r <= cc_nxt;
            arm_r <= arm_nxt;
            clr_r <= clr_nxt;
            ccm_r <= ccc_r;
        end
    end
    assign error_counter_clear = clr_r;

    ////////////////////////////////////////////////////////////////////////
    // torque limit selection
    logic [8:0] fl_nxt, rl_nxt, fl_r, rl_r;
    always_comb begin
        fl_nxt = tl1_r;
        rl_nxt = tl1_r;
        if (tqm_r) begin
            fl_nxt = tl1_r;
            rl_nxt = tl1_r;
        end else if (tlm_r == 3'h0 || tlm_r == 3'h4 || tlm_r == 3'h5) begin
            // reverse input is a magnitude; method 0 span is negative at the pin
            fl_nxt = forward_analog_torque_limit;
            rl_nxt = reverse_analog_torque_limit;
        end else if (tlm_r == 3'h2) begin
            rl_nxt = tl2_r;
        end else if (tlm_r == 3'h3 && torque_limit_switch_input) begin
            fl_nxt = tl2_r;
            rl_nxt = tl2_r;
        end else if (tlm_r == 3'h6) begin
            fl_nxt = torque_limit_switch_input ? tlf_r : tl1_r;
            rl_nxt = torque_limit_switch_input ? tlr_r : tl2_r;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fl_r <= sqtl_pkg::R_TLIM;
            rl_r <= sqtl_pkg::R_TLIM;
        end else begin
            fl_r <= fl_nxt;
            rl_r <= rl_nxt;
        end
    end
    assign forward_torque_limit = fl_r;
    assign reverse_torque_limit = rl_r;

    ////////////////////////////////////////////////////////////////////////
    // checks
    logic [31:0] hi_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_r <= 32'h0;
        end else begin
            hi_r <= counter_clear_input ? hi_r + 32'h1 : 32'h0;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_mode_held(logic [2:0] m);
        ccc_r == m ##1 ccc_r == m;
    endsequence
    AST_CLR_OFF: assert property (s_mode_held(sqtl_pkg::CLR_OFF) |-> !clr_r)
        else $error("clear in disabled mode");
    AST_CLR_500: assert property ($rose(clr_r) && ccc_r == sqtl_pkg::CLR_LVL500 |-> hi_r >= 32'(P_CLR500))
        else $error("level clear before 500 us");
    AST_CLR_1MS: assert property ($rose(clr_r) && ccc_r == sqtl_pkg::CLR_LVL1MS |-> hi_r >= 32'(P_CLR1MS))
        else $error("level clear before 1 ms");
    AST_EDGE_100: assert property (clr_r && ccc_r == sqtl_pkg::CLR_EDG100 |-> hi_r >= 32'(P_CLR100) ##1 !clr_r)
        else $error("edge clear not single or too early");
    AST_EDGE_1MS: assert property (clr_r && ccc_r == sqtl_pkg::CLR_EDG1MS |-> hi_r >= 32'(P_CLR1MS) ##1 !clr_r)
        else $error("edge clear not single or too early");
    AST_INH_OFF: assert property (pie_r |-> pulse_count_enable)
        else $error("inhibit honoured while disabled");
    AST_INH_HALT: assert property (!pulse_count_enable |=> pcnt_r == $past(pcnt_r))
        else $error("pulses counted while inhibited");
    AST_RAW_SMP: assert property (inh_tick && pisp_r == sqtl_pkg::PISP_RAW |=> inh_q_r == $past(pulse_inhibit_input))
        else $error("raw inhibit sample not taken");
    AST_AR_120: assert property ($rose(ar_q_r) && !arcs_r |-> ar_cnt_r >= 32'(P_AR))
        else $error("alarm reset confirmed too early");
    AST_TQ_MODE: assert property (tqm_r ##1 tqm_r |-> fl_r == $past(tl1_r) && rl_r == $past(tl1_r))
        else $error("torque mode limit not limit one");
endmodule
